// ---- sfw_top.v ----
`include "sfw_regs.vh"
`default_nettype none

module sfw_top #(
  parameter CLK_MHZ        = `SFW_CLK_MHZ,
  parameter SMALL_WIPE_US  = `SFW_SMALL_WIPE_US,
  parameter MID_WIPE_US    = `SFW_MID_WIPE_US,
  parameter LARGE_WIPE_US  = `SFW_LARGE_WIPE_US,
  parameter WHOLE_WIPE_US  = `SFW_WHOLE_WIPE_US,
  parameter SLEEP_ENTRY_US = `SFW_SLEEP_ENTRY_US,
  parameter WAKE_US        = `SFW_WAKE_US
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_b,
  // Serial link pins
  input  wire        spi_sclk,
  input  wire        spi_cs_b,
  input  wire [3:0]  spi_dq_in,
  // Protection and surrounding state
  input  wire [3:0]  protect_range_bits,
  input  wire        extra_lock_flag,
  input  wire        protect_query_hit,
  input  wire        write_suspended,
  input  wire        ext_cycle_busy,
  // Protection query
  output wire [23:0] protect_query_addr,
  // Wipe request to the array
  output wire        wipe_start,
  output wire [1:0]  wipe_kind,
  output wire [23:0] wipe_base_addr,
  output wire [7:0]  wipe_fill_byte,
  output wire        wipe_done,
  // Status
  output wire        cycle_active_flag,
  output wire        write_unlock_latch,
  output wire        quad_command_mode,
  output wire        otp_mode,
  output wire        deep_sleep,
  output wire        standby,
  output wire        cmd_dropped
);

  // Cycle counts from times
  localparam [31:0] SMALL_CYC = SMALL_WIPE_US * CLK_MHZ;
  localparam [31:0] MID_CYC   = MID_WIPE_US * CLK_MHZ;
  localparam [31:0] LARGE_CYC = LARGE_WIPE_US * CLK_MHZ;
  localparam [31:0] WHOLE_CYC = WHOLE_WIPE_US * CLK_MHZ;
  localparam [31:0] SLEEP_CYC = SLEEP_ENTRY_US * CLK_MHZ;
  localparam [31:0] WAKE_CYC  = WAKE_US * CLK_MHZ;

  wire [5:0]  pins_s;
  wire        sclk_s;
  wire        cs_b_s;
  wire [3:0]  dq_s;
  reg         sclk_prev_reg;
  reg         cs_b_prev_reg;
  reg  [31:0] shift_reg;
  reg  [31:0] shift_next;
  reg  [5:0]  bit_cnt_reg;
  reg  [5:0]  bit_cnt_next;
  reg  [7:0]  opcode_reg;
  reg         unlock_reg;
  reg         quad_reg;
  reg         otp_reg;
  reg  [1:0]  power_reg;
  reg  [1:0]  power_next;
  reg         wipe_start_reg;
  reg  [1:0]  wipe_kind_reg;
  reg  [23:0] wipe_base_reg;
  reg         dropped_reg;
  reg         standby_reg;
  reg         wipe_go;
  reg  [1:0]  go_kind;
  reg  [31:0] wipe_load;
  reg         sleep_go;
  reg         wake_go;
  reg         do_unlock;
  reg         do_lock;
  reg         do_quad;
  reg         do_otp;
  reg         do_reset;
  reg         do_drop;
  reg  [23:0] unit_mask;
  wire        wipe_busy;
  wire        pw_busy;
  wire        pw_done;
  wire        sclk_rise;
  wire        cs_rise;
  wire        cs_fall;
  wire        busy_any;
  wire        asleep;
  wire        frame_op;
  wire        frame_addr;
  wire [23:0] addr_w;
  wire [31:0] pw_load;

  // Pin synchroniser
  sfw_sync3 #(
    .W(6)
  ) u_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .async_in ({spi_sclk, spi_cs_b, spi_dq_in}),
    .sync_out (pins_s)
  );

  assign sclk_s = pins_s[5];
  assign cs_b_s = pins_s[4];
  assign dq_s   = pins_s[3:0];

  // Edge detection on filtered pins
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev_reg <= 1'b1;
      cs_b_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_s;
      cs_b_prev_reg <= cs_b_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_prev_reg;
  assign cs_rise   = cs_b_s & ~cs_b_prev_reg;
  assign cs_fall   = ~cs_b_s & cs_b_prev_reg;

  // Bit shifting, one or four bits per rising clock edge
  always @* begin
    shift_next   = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    if (cs_fall) begin
      bit_cnt_next = 6'h00;
    end else if (sclk_rise && !cs_b_s) begin
      if (quad_reg) begin
        shift_next = {shift_reg[27:0], dq_s};
        if (bit_cnt_reg < `SFW_BITS_SATURATE) begin
          bit_cnt_next = bit_cnt_reg + 6'h04;
        end
      end else begin
        shift_next = {shift_reg[30:0], dq_s[0]};
        if (bit_cnt_reg < `SFW_BITS_SATURATE) begin
          bit_cnt_next = bit_cnt_reg + 6'h01;
        end
      end
    end
  end

  // Shift state and opcode capture
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg   <= 32'h00000000;
      bit_cnt_reg <= 6'h00;
      opcode_reg  <= 8'h00;
    end else begin
      shift_reg   <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      if (bit_cnt_next == `SFW_BITS_OPCODE && bit_cnt_reg != `SFW_BITS_OPCODE) begin
        opcode_reg <= shift_next[7:0];
      end
    end
  end

  // Frame length is counted only while select stays low
  assign frame_op   = (bit_cnt_reg == `SFW_BITS_OPCODE);
  assign frame_addr = (bit_cnt_reg == `SFW_BITS_ADDRESSED);
  assign addr_w     = shift_reg[23:0];
  assign busy_any   = wipe_busy | ext_cycle_busy;
  assign asleep     = (power_reg != `SFW_PW_STANDBY);
  assign protect_query_addr = addr_w;

  // Command decode at the rise of chip select
  always @* begin
    wipe_go   = 1'b0;
    go_kind   = `SFW_KIND_SMALL;
    sleep_go  = 1'b0;
    wake_go   = 1'b0;
    do_unlock = 1'b0;
    do_lock   = 1'b0;
    do_quad   = 1'b0;
    do_otp    = 1'b0;
    do_reset  = 1'b0;
    do_drop   = 1'b0;
    if (cs_rise) begin
      if (asleep) begin
        // Only wake and soft reset while asleep
        if (frame_op && opcode_reg == `SFW_OP_SOFT_RESET) begin
          do_reset = 1'b1;
        end else if (frame_op && opcode_reg == `SFW_OP_WAKE_AND_ID &&
                     power_reg == `SFW_PW_SLEEP) begin
          wake_go = 1'b1;
        end else begin
          do_drop = 1'b1;
        end
      end else if (busy_any) begin
        // Sleep and every other command refused mid-cycle
        do_drop = 1'b1;
      end else begin
        case (opcode_reg)
          `SFW_OP_SMALL_WIPE, `SFW_OP_MID_WIPE, `SFW_OP_LARGE_WIPE: begin
            if (opcode_reg == `SFW_OP_SMALL_WIPE) begin
              go_kind = `SFW_KIND_SMALL;
            end else if (opcode_reg == `SFW_OP_MID_WIPE) begin
              go_kind = `SFW_KIND_MID;
            end else begin
              go_kind = `SFW_KIND_LARGE;
            end
            if (frame_addr && unlock_reg && !protect_query_hit &&
                (!otp_reg || go_kind == `SFW_KIND_SMALL)) begin
              wipe_go = 1'b1;
            end else begin
              do_drop = 1'b1;
            end
          end
          `SFW_OP_WHOLE_WIPE_A, `SFW_OP_WHOLE_WIPE_B: begin
            go_kind = `SFW_KIND_WHOLE;
            // Eight bits only, nothing locked, no suspend
            if (frame_op && unlock_reg && protect_range_bits == 4'h0 &&
                !extra_lock_flag && !write_suspended && !otp_reg) begin
              wipe_go = 1'b1;
            end else begin
              do_drop = 1'b1;
            end
          end
          `SFW_OP_DEEP_SLEEP: begin
            // Sleep entry only through this opcode
            if (frame_op) begin
              sleep_go = 1'b1;
            end else begin
              do_drop = 1'b1;
            end
          end
          `SFW_OP_WRITE_UNLOCK: begin
            do_unlock = frame_op;
            do_drop   = !frame_op;
          end
          `SFW_OP_WRITE_LOCK: begin
            do_lock = frame_op;
            do_drop = !frame_op;
          end
          `SFW_OP_QUAD_ENTER: begin
            do_quad = frame_op;
            do_drop = !frame_op;
          end
          `SFW_OP_OTP_ENTER: begin
            do_otp  = frame_op;
            do_drop = !frame_op;
          end
          `SFW_OP_SOFT_RESET: begin
            do_reset = frame_op;
            do_drop  = !frame_op;
          end
          default: begin
            do_drop = 1'b0;
          end
        endcase
      end
    end
  end

  // Unit size and duration by kind
  always @* begin
    case (go_kind)
      `SFW_KIND_SMALL: begin
        unit_mask = `SFW_MASK_SMALL;
        wipe_load = SMALL_CYC;
      end
      `SFW_KIND_MID: begin
        unit_mask = `SFW_MASK_MID;
        wipe_load = MID_CYC;
      end
      `SFW_KIND_LARGE: begin
        unit_mask = `SFW_MASK_LARGE;
        wipe_load = LARGE_CYC;
      end
      default: begin
        unit_mask = `SFW_MASK_WHOLE;
        wipe_load = WHOLE_CYC;
      end
    endcase
  end

  // Self-timed wipe cycle from select rise
  sfw_timer #(
    .W(32)
  ) u_wipe_timer (
    .clock      (clock),
    .rst_b      (rst_b),
    .start      (wipe_go),
    .load_value (wipe_load),
    .busy       (wipe_busy),
    .done       (wipe_done)
  );

  assign pw_load = sleep_go ? SLEEP_CYC : WAKE_CYC;

  // Sleep entry and wake delays
  sfw_timer #(
    .W(32)
  ) u_power_timer (
    .clock      (clock),
    .rst_b      (rst_b),
    .start      (sleep_go | wake_go),
    .load_value (pw_load),
    .busy       (pw_busy),
    .done       (pw_done)
  );

  // Power state machine
  always @* begin
    power_next = power_reg;
    case (power_reg)
      `SFW_PW_STANDBY: begin
        if (sleep_go) begin
          power_next = `SFW_PW_SLEEP_ENTER;
        end
      end
      `SFW_PW_SLEEP_ENTER: begin
        if (do_reset) begin
          power_next = `SFW_PW_STANDBY;
        end else if (pw_done) begin
          power_next = `SFW_PW_SLEEP;
        end
      end
      `SFW_PW_SLEEP: begin
        if (do_reset) begin
          power_next = `SFW_PW_STANDBY;
        end else if (wake_go) begin
          power_next = `SFW_PW_WAKE;
        end
      end
      `SFW_PW_WAKE: begin
        // Commands accepted once wake delay ends
        if (do_reset || pw_done) begin
          power_next = `SFW_PW_STANDBY;
        end
      end
      default: begin
        power_next = `SFW_PW_STANDBY;
      end
    endcase
  end

  // Mode flags, latch and wipe request registers
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      power_reg      <= `SFW_PW_STANDBY;
      unlock_reg     <= 1'b0;
      quad_reg       <= 1'b0;
      otp_reg        <= 1'b0;
      wipe_start_reg <= 1'b0;
      wipe_kind_reg  <= `SFW_KIND_SMALL;
      wipe_base_reg  <= 24'h000000;
      dropped_reg    <= 1'b0;
      standby_reg    <= 1'b1;
    end else begin
      power_reg      <= power_next;
      wipe_start_reg <= wipe_go;
      dropped_reg    <= do_drop;
      if (wipe_go) begin
        wipe_kind_reg <= go_kind;
        wipe_base_reg <= addr_w & unit_mask;
      end
      // Latch clears as the wipe starts
      if (wipe_go || do_lock || do_reset) begin
        unlock_reg <= 1'b0;
      end
      if (do_unlock) begin
        unlock_reg <= 1'b1;
      end
      if (do_quad) begin
        quad_reg <= 1'b1;
      end else if (do_reset) begin
        quad_reg <= 1'b0;
      end
      if (do_otp) begin
        otp_reg <= 1'b1;
      end else if (do_lock || do_reset) begin
        otp_reg <= 1'b0;
      end
      standby_reg <= (power_next == `SFW_PW_STANDBY) && cs_b_s &&
                     !wipe_go && !wipe_busy && !ext_cycle_busy;
    end
  end

  assign wipe_fill_byte     = `SFW_ERASED_BYTE;
  assign wipe_start         = wipe_start_reg;
  assign wipe_kind          = wipe_kind_reg;
  assign wipe_base_addr     = wipe_base_reg;
  assign cycle_active_flag  = wipe_busy;
  assign write_unlock_latch = unlock_reg;
  assign quad_command_mode  = quad_reg;
  assign otp_mode           = otp_reg;
  assign deep_sleep         = (power_reg == `SFW_PW_SLEEP);
  assign standby            = standby_reg;
  assign cmd_dropped        = dropped_reg;

endmodule

`default_nettype wire

// ---- sfw_regs.vh ----
`ifndef SFW_REGS_VH
`define SFW_REGS_VH

// Command opcodes
`define SFW_OP_SMALL_WIPE    8'h20
`define SFW_OP_MID_WIPE      8'h52
`define SFW_OP_LARGE_WIPE    8'hD8
`define SFW_OP_WHOLE_WIPE_A  8'hC7
`define SFW_OP_WHOLE_WIPE_B  8'h60
`define SFW_OP_DEEP_SLEEP    8'hB9
`define SFW_OP_WAKE_AND_ID   8'hAB
`define SFW_OP_WRITE_UNLOCK  8'h06
`define SFW_OP_WRITE_LOCK    8'h04
`define SFW_OP_QUAD_ENTER    8'h38
`define SFW_OP_OTP_ENTER     8'h3A
`define SFW_OP_SOFT_RESET    8'h99

// Frame lengths in serial bits
`define SFW_BITS_OPCODE      6'h08
`define SFW_BITS_ADDRESSED   6'h20
`define SFW_BITS_SATURATE    6'h28

// Wipe unit kinds
`define SFW_KIND_SMALL       2'h0
`define SFW_KIND_MID         2'h1
`define SFW_KIND_LARGE       2'h2
`define SFW_KIND_WHOLE       2'h3

// Unit alignment masks
`define SFW_MASK_SMALL       24'hFFF000
`define SFW_MASK_MID         24'hFF8000
`define SFW_MASK_LARGE       24'hFF0000
`define SFW_MASK_WHOLE       24'h000000

// Erased byte value
`define SFW_ERASED_BYTE      8'hFF

// Power states
`define SFW_PW_STANDBY       2'h0
`define SFW_PW_SLEEP_ENTER   2'h1
`define SFW_PW_SLEEP         2'h2
`define SFW_PW_WAKE          2'h3

// Clock rate and timing figures in microseconds
`define SFW_CLK_MHZ          25
`define SFW_SMALL_WIPE_US    1000
`define SFW_MID_WIPE_US      2000
`define SFW_LARGE_WIPE_US    3000
`define SFW_WHOLE_WIPE_US    10000
`define SFW_SLEEP_ENTRY_US   3
`define SFW_WAKE_US          3

`endif

// ---- sfw_sync3.v ----
`default_nettype none

module sfw_sync3 #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         clock,
  input  wire         rst_b,
  // Asynchronous inputs and filtered result
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  genvar gi;

  // Three stages per bit, output moves when stages two and three agree
  generate
    for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg out_reg;
      always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          s1_reg  <= 1'b1;
          s2_reg  <= 1'b1;
          s3_reg  <= 1'b1;
          out_reg <= 1'b1;
        end else begin
          s1_reg <= async_in[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            out_reg <= s3_reg;
          end
        end
      end
      assign sync_out[gi] = out_reg;
    end
  endgenerate

endmodule

`default_nettype wire

// ---- sfw_timer.v ----
`default_nettype none

module sfw_timer #(
  parameter W = 32
) (
  // Clock and reset
  input  wire         clock,
  input  wire         rst_b,
  // Start with a cycle count
  input  wire         start,
  input  wire [W-1:0] load_value,
  // Status
  output wire         busy,
  output wire         done
);

  reg [W-1:0] cnt_reg;
  reg         busy_reg;
  reg         done_reg;

  // Busy for exactly load_value cycles, then one done pulse
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg  <= {W{1'b0}};
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (start) begin
        cnt_reg  <= load_value - {{(W-1){1'b0}}, 1'b1};
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        if (cnt_reg == {W{1'b0}}) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;

endmodule

`default_nettype wire

// ---- sfw_checker.sv ----
`default_nettype none
module sfw_checker #(
  parameter int CLK_MHZ       = 25,
  parameter int SMALL_WIPE_US = 1,
  parameter int MID_WIPE_US   = 1,
  parameter int LARGE_WIPE_US = 1,
  parameter int WHOLE_WIPE_US = 1
) (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // Gating inputs
  input wire logic [3:0]  protect_range_bits,
  input wire logic        extra_lock_flag,
  input wire logic        protect_query_hit,
  input wire logic        write_suspended,
  // Wipe outputs
  input wire logic        wipe_start,
  input wire logic [1:0]  wipe_kind,
  input wire logic [23:0] wipe_base_addr,
  input wire logic [7:0]  wipe_fill_byte,
  input wire logic        wipe_done,
  // Status outputs
  input wire logic        cycle_active_flag,
  input wire logic        write_unlock_latch,
  input wire logic        otp_mode,
  input wire logic        deep_sleep,
  input wire logic        standby
);
  timeunit 1ns;
  timeprecision 1ps;
  int          run_cnt;
  int          exp_len;
  logic [23:0] keep_mask;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Busy length and address mask of the current kind
  assign exp_len = (wipe_kind == 2'h0) ? SMALL_WIPE_US * CLK_MHZ :
                   (wipe_kind == 2'h1) ? MID_WIPE_US * CLK_MHZ :
                   (wipe_kind == 2'h2) ? LARGE_WIPE_US * CLK_MHZ : WHOLE_WIPE_US * CLK_MHZ;
  assign keep_mask = (wipe_kind == 2'h0) ? 24'hFFF000 : (wipe_kind == 2'h1) ? 24'hFF8000 :
                     (wipe_kind == 2'h2) ? 24'hFF0000 : 24'h000000;
  // Cycles spent with the busy flag high
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      run_cnt <= 0;
    else
      run_cnt <= cycle_active_flag ? run_cnt + 1 : 0;
  end
  AST_FILL: assert property (wipe_fill_byte == 8'hFF)
    else $error("fill byte not all ones");
  AST_UNLOCK: assert property (wipe_start |-> $past(write_unlock_latch) && !write_unlock_latch)
    else $error("wipe started without latch or latch kept");
  AST_BUSY: assert property (wipe_start |-> cycle_active_flag ##1 cycle_active_flag[*8])
    else $error("busy flag not raised with start");
  AST_LEN: assert property (wipe_done |-> !cycle_active_flag && run_cnt == exp_len)
    else $error("busy length wrong");
  AST_ALIGN: assert property (wipe_start |-> (wipe_base_addr & ~keep_mask) == 24'h000000)
    else $error("base not aligned");
  AST_PROT: assert property (wipe_start && wipe_kind != 2'h3 |-> !$past(protect_query_hit))
    else $error("protected unit wiped");
  AST_WHOLE: assert property (wipe_start && wipe_kind == 2'h3 |->
    $past(protect_range_bits) == 4'h0 && !$past(extra_lock_flag) && !$past(write_suspended))
    else $error("whole wipe while guarded");
  AST_OTP: assert property (wipe_start && $past(otp_mode) |-> wipe_kind == 2'h0)
    else $error("large wipe in otp mode");
  AST_ASLEEP: assert property ($past(deep_sleep) |-> !wipe_start)
    else $error("wipe while asleep");
  AST_QUIET: assert property (cycle_active_flag |-> !deep_sleep && !standby)
    else $error("sleep or standby during wipe");
  cover property (wipe_start && wipe_kind == 2'h3);
  cover property ($rose(deep_sleep));
  cover property (wipe_done);
endmodule
`default_nettype wire

// ---- sfw_host.sv ----
`default_nettype none
module sfw_host (
  // Link pins toward the device
  output var logic       spi_sclk,
  output var logic       spi_cs_b,
  output var logic [3:0] spi_dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: deselected, clock parked high
  initial begin
    spi_sclk = 1'b1;
    spi_cs_b = 1'b1;
    spi_dq_in = 4'h0;
  end
  // One frame of n bits, MSB first, nibbles in quad mode
  task frame(input logic [39:0] v, input int n, input logic quad);
    int i;
    // select low for the whole frame
    spi_cs_b = 1'b0;
    for (i = n - 1; i >= 0; i = i - (quad ? 4 : 1)) begin
      #160 spi_sclk = 1'b0;
      spi_dq_in = quad ? v[i -: 4] : {~spi_dq_in[3:1], v[i]};
      #160 spi_sclk = 1'b1;
    end
    #160 spi_dq_in = ~spi_dq_in;
    // select rises after the last bit
    spi_cs_b = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// ---- test_serial_flash_erase_and_sleep.sv ----
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
`define WAIT(c) begin for (int k = 0; k < 300 && !(c); k++) @(posedge clock); \
  if (!(c)) mismatches++; end
module test_serial_flash_erase_and_sleep;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        rst_b;
  logic [3:0]  protect_range_bits;
  logic        extra_lock_flag;
  logic        write_suspended;
  logic        ext_cycle_busy;
  logic        q;
  wire         spi_sclk, spi_cs_b, protect_query_hit, wipe_start, wipe_done;
  wire         cycle_active_flag, write_unlock_latch, quad_command_mode, otp_mode;
  wire         deep_sleep, standby, cmd_dropped;
  wire [3:0]   spi_dq_in;
  wire [1:0]   wipe_kind;
  wire [7:0]   wipe_fill_byte;
  wire [23:0]  protect_query_addr, wipe_base_addr;
  int          checks = 0, mismatches = 0, starts = 0, dones = 0, drops = 0;
  // Protected region starts at 7E0000
  assign protect_query_hit = protect_query_addr[23:16] == 8'h7E;
  sfw_host host_u (.spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_dq_in(spi_dq_in));
  sfw_top #(.SMALL_WIPE_US(1), .MID_WIPE_US(1), .LARGE_WIPE_US(1), .WHOLE_WIPE_US(8),
    .SLEEP_ENTRY_US(1)) dut_u (.clock(clock), .rst_b(rst_b),
    .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_dq_in(spi_dq_in),
    .protect_range_bits(protect_range_bits), .extra_lock_flag(extra_lock_flag),
    .protect_query_hit(protect_query_hit), .write_suspended(write_suspended),
    .ext_cycle_busy(ext_cycle_busy), .protect_query_addr(protect_query_addr),
    .wipe_start(wipe_start), .wipe_kind(wipe_kind), .wipe_base_addr(wipe_base_addr),
    .wipe_fill_byte(wipe_fill_byte), .wipe_done(wipe_done),
    .cycle_active_flag(cycle_active_flag), .write_unlock_latch(write_unlock_latch),
    .quad_command_mode(quad_command_mode), .otp_mode(otp_mode),
    .deep_sleep(deep_sleep), .standby(standby), .cmd_dropped(cmd_dropped));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Event counters
  always @(posedge clock) begin
    if (wipe_start === 1'b1) starts <= starts + 1;
    if (wipe_done === 1'b1) dones <= dones + 1;
    if (cmd_dropped === 1'b1) drops <= drops + 1;
  end
  task end_sim;
    if (mismatches == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One frame, then start expected or not, and the whole cycle
  task run(input logic [39:0] v, input int n, input logic e);
    int s0;
    s0 = starts;
    host_u.frame(v, n, q);
    `CHK("start", e, starts != s0)
    if (e) begin
      `CHK("busy", 1'b1, cycle_active_flag)
      `CHK("latch", 1'b0, write_unlock_latch)
      `CHK("standby", 1'b0, standby)
      `WAIT(dones == starts)
      @(negedge clock);
      `CHK("idle", 2'h1, {cycle_active_flag, standby})
    end
  endtask
  task t_reset;
    `CHK("pwr", 3'h4, {standby, deep_sleep, write_unlock_latch})
    host_u.frame(40'h06, 8, q);
    host_u.frame(40'hB9, 8, q);
    `WAIT(deep_sleep === 1'b1)
    @(negedge clock) rst_b = 1'b0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    repeat (4) @(negedge clock);
    `CHK("pwr", 3'h4, {standby, deep_sleep, write_unlock_latch})
  endtask
  task t_sizes;
    logic [7:0]  ops [5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
    logic [23:0] bases [5] = '{24'h12A000, 24'h128000, 24'h120000, 24'h0, 24'h0};
    int i;
    run({8'h20, 24'h12ABCD}, 32, 1'b0);
    for (i = 0; i < 5; i++) begin
      host_u.frame(40'h06, 8, q);
      `CHK("latch", 1'b1, write_unlock_latch)
      run(i < 3 ? {8'h0, ops[i], 24'h12ABCD} : {32'h0, ops[i]}, i < 3 ? 32 : 8, 1'b1);
      `CHK("kind", i < 4 ? i[1:0] : 2'h3, wipe_kind)
      `CHK("base", bases[i], wipe_base_addr)
    end
  endtask
  task t_frame;
    int d0;
    host_u.frame(40'h06, 8, q);
    d0 = drops;
    run({8'h20, 24'h12ABCD} >> 1, 31, 1'b0);
    run({8'h20, 24'h12ABCD, 8'h00}, 40, 1'b0);
    run({8'hC7, 1'b0}, 9, 1'b0);
    `CHK("drops", 3, drops - d0)
  endtask
  task t_protect;
    int i;
    host_u.frame(40'h06, 8, q);
    run({8'h20, 24'h7E1234}, 32, 1'b0);
    for (i = 0; i < 3; i++) begin
      @(negedge clock);
      protect_range_bits = (i == 0) ? 4'h8 : 4'h0;
      extra_lock_flag = i == 1;
      write_suspended = i == 2;
      host_u.frame(40'h06, 8, q);
      run(40'hC7, 8, 1'b0);
    end
    @(negedge clock);
    write_suspended = 1'b0;
  endtask
  task t_sleep;
    host_u.frame(40'h04, 8, q);
    host_u.frame(40'hB9, 8, q);
    `CHK("early", 1'b0, deep_sleep)
    `WAIT(deep_sleep === 1'b1)
    `CHK("asleep", 1'b1, deep_sleep)
    host_u.frame(40'h06, 8, q);
    `CHK("latch", 1'b0, write_unlock_latch)
    run({8'h20, 24'h001000}, 32, 1'b0);
    host_u.frame(40'hAB, 8, q);
    `WAIT(standby === 1'b1)
    `CHK("awake", 2'h1, {deep_sleep, standby})
  endtask
  task t_busy;
    int d0;
    host_u.frame(40'h06, 8, q);
    host_u.frame(40'hC7, 8, q);
    d0 = drops;
    host_u.frame(40'hB9, 8, q);
    `WAIT(dones == starts)
    repeat (40) @(posedge clock);
    `CHK("sleep", 1'b0, deep_sleep)
    `CHK("drops", 1, drops - d0)
    @(negedge clock) ext_cycle_busy = 1'b1;
    host_u.frame(40'hB9, 8, q);
    repeat (40) @(posedge clock);
    `CHK("sleep", 2'h0, {deep_sleep, standby})
    @(negedge clock) ext_cycle_busy = 1'b0;
  endtask
  task t_quad;
    host_u.frame(40'h38, 8, 1'b0);
    `CHK("quad", 1'b1, quad_command_mode)
    q = 1'b1;
    host_u.frame(40'h06, 8, q);
    run({8'h52, 24'h2ABCDE}, 32, 1'b1);
    `CHK("base", 24'h2A8000, wipe_base_addr)
    host_u.frame(40'hB9, 8, q);
    `WAIT(deep_sleep === 1'b1)
    `CHK("asleep", 1'b1, deep_sleep)
    host_u.frame(40'h99, 8, q);
    `WAIT(standby === 1'b1)
    `CHK("reset", 2'h0, {deep_sleep, quad_command_mode})
    q = 1'b0;
  endtask
  task t_otp;
    host_u.frame(40'h3A, 8, q);
    `CHK("otp", 1'b1, otp_mode)
    host_u.frame(40'h06, 8, q);
    run({8'hD8, 24'h120000}, 32, 1'b0);
    host_u.frame(40'h06, 8, q);
    run({8'h20, 24'h005000}, 32, 1'b1);
    host_u.frame(40'h04, 8, q);
    `CHK("otp", 1'b0, otp_mode)
  endtask
  // Watchdog against a hang
  initial begin
    #2000000;
    mismatches++;
    end_sim;
  end
  initial begin
    rst_b = 1'b0;
    protect_range_bits = 4'h0;
    extra_lock_flag = 1'b0;
    write_suspended = 1'b0;
    ext_cycle_busy = 1'b0;
    q = 1'b0;
    repeat (16) @(posedge clock);
    @(negedge clock) rst_b = 1'b1;
    repeat (4) @(negedge clock);
    t_reset;
    t_sizes;
    t_frame;
    t_protect;
    t_sleep;
    t_busy;
    t_quad;
    t_otp;
    end_sim;
  end
endmodule
bind sfw_top sfw_checker #(.CLK_MHZ(CLK_MHZ), .SMALL_WIPE_US(SMALL_WIPE_US),
  .MID_WIPE_US(MID_WIPE_US), .LARGE_WIPE_US(LARGE_WIPE_US), .WHOLE_WIPE_US(WHOLE_WIPE_US))
  chk_u (.clock(clock), .rst_b(rst_b), .protect_range_bits(protect_range_bits),
  .extra_lock_flag(extra_lock_flag), .protect_query_hit(protect_query_hit),
  .write_suspended(write_suspended), .wipe_start(wipe_start), .wipe_kind(wipe_kind),
  .wipe_base_addr(wipe_base_addr), .wipe_fill_byte(wipe_fill_byte), .wipe_done(wipe_done),
  .cycle_active_flag(cycle_active_flag), .write_unlock_latch(write_unlock_latch),
  .otp_mode(otp_mode), .deep_sleep(deep_sleep), .standby(standby));
`default_nettype wire
